// >>> logic/dscp_pkg.sv
package dscp_pkg;

  // register addresses on the serial port
  localparam logic [4:0] ADDR_CFG = 5'h00;
  localparam logic [4:0] ADDR_DIV = 5'h03;
  localparam logic [4:0] ADDR_CP = 5'h04;
  localparam logic [4:0] ADDR_I_FINE = 5'h05;
  localparam logic [4:0] ADDR_I_COARSE = 5'h06;
  localparam logic [4:0] ADDR_I_OFS_HI = 5'h07;
  localparam logic [4:0] ADDR_I_OFS_LO = 5'h08;
  localparam logic [4:0] ADDR_Q_FINE = 5'h09;
  localparam logic [4:0] ADDR_Q_COARSE = 5'h0A;
  localparam logic [4:0] ADDR_Q_OFS_HI = 5'h0B;
  localparam logic [4:0] ADDR_Q_OFS_LO = 5'h0C;
  localparam int REG_SLOTS = 13;

  // field positions
  localparam int CFG_BIDIR_BIT = 7;
  localparam int CFG_LSB_BIT = 6;
  localparam int CFG_SWRST_BIT = 5;
  localparam int CFG_PD_BIT = 3;
  localparam int CP_PLL_EN_BIT = 7;
  localparam int CP_MANUAL_BIT = 6;
  localparam int OFS_DIR_BIT = 7;
  localparam int INSTR_RW_BIT = 7;

  // writable bits per register, others read zero
  localparam logic [7:0] CFG_WMASK = 8'hC8;
  localparam logic [7:0] DIV_WMASK = 8'h03;
  localparam logic [7:0] CP_WMASK = 8'hC7;
  localparam logic [7:0] FINE_WMASK = 8'hFF;
  localparam logic [7:0] COARSE_WMASK = 8'h0F;
  localparam logic [7:0] OFS_HI_WMASK = 8'hFF;
  localparam logic [7:0] OFS_LO_WMASK = 8'h83;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] SYNC_IDLE_HIGH = 3'h7;
  localparam int CLK_HZ = 50_000_000;

  typedef enum logic [1:0] {PH_INSTR, PH_DATA, PH_DONE} dscp_phase_e;

  typedef struct packed {
    logic [7:0] fine;
    logic [3:0] coarse;
    logic [9:0] offset;
    logic offset_to_b;
  } dscp_chan_s;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] sclk_sync;
    logic [2:0] sdi_sync;
    logic cs_st;
    logic sclk_st;
    dscp_phase_e phase;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic [1:0] nleft;
    logic [4:0] addr;
    logic [7:0] txreg;
    logic tx_bit;
    logic [REG_SLOTS-1:0][7:0] regs;
  } dscp_state_s;

endpackage : dscp_pkg

// >>> logic/dscp_serial_port.sv
// How it works
// (RULE1) divider code 00,01,10,11 selects ratio one, two, four, eight
// (RULE2) pll enable bit 7 of 04h resets to zero, one enables pll
// (RULE3) charge pump mode bit 6 of 04h: zero automatic, one manual
// (RULE4) manual mode uses three low bits of 04h as bias code
// (RULE5) eight-bit fine gain per channel at 05h and 09h
// (RULE6) four-bit coarse gain per channel in low bits of 06h, 0Ah
// (RULE7) ten-bit offset from upper byte plus two low bits of next register
// (RULE8) bit 7 of 08h/0Ch routes offset to first or second output
// (RULE9) instruction byte captured on first eight rising serial clock edges
// (RULE10) chip select high then low restarts at instruction phase
// (RULE11) partial byte at abort is dropped, never written
// (RULE12) each register updates right after its last data bit
// (RULE13) instruction bit 7 one means read, zero means write
// (RULE14) instruction bits 6:5 give one to four data bytes
// (RULE15) instruction bits 4:0 give the first register address
// (RULE16) later byte addresses are generated internally
// (RULE17) single bidirectional pin or separate input and output pins
// (RULE18) serial port keeps working while power-down is set
// (RULE19) sample on rising serial clock, drive on falling edge
// (RULE20) both data outputs released while chip select is high
// (RULE21) address decrements msb-first, increments lsb-first
// (RULE22) config bit, default zero, lets bidirectional pin drive reads
// (RULE23) read phase shifts out each addressed register byte by byte
`timescale 1ns/1ps

module dscp_serial_port
  import dscp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic chip_select_low,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  output logic serial_data_output,
  output logic serial_data_output_oe_n,
  output logic power_down,
  output logic pll_enable,
  output logic [1:0] clk_div_code,
  output logic [3:0] clk_div_ratio,
  output logic cp_manual,
  output logic [2:0] cp_bias_code,
  output dscp_chan_s chan_i,
  output dscp_chan_s chan_q
);

  dscp_state_s st;
  dscp_state_s next_st;

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic lsb);
    shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction : shift_in

  function automatic logic [4:0] step_addr(input logic [4:0] a, input logic lsb);
    step_addr = lsb ? a + 5'h01 : a - 5'h01;
  endfunction : step_addr

  function automatic logic held_addr(input logic [4:0] a);
    held_addr = (a == ADDR_CFG) || ((a >= ADDR_DIV) && (a <= ADDR_Q_OFS_LO));
  endfunction : held_addr

  function automatic logic [7:0] read_reg(input logic [REG_SLOTS-1:0][7:0] r,
                                          input logic [4:0] a);
    if (held_addr(a)) begin
      read_reg = r[a[3:0]];
    end else begin
      read_reg = 8'h00;
    end
  endfunction : read_reg

  function automatic logic [7:0] wmask(input logic [4:0] a);
    if (a == ADDR_CFG) begin
      wmask = CFG_WMASK;
    end else if (a == ADDR_DIV) begin
      wmask = DIV_WMASK;
    end else if (a == ADDR_CP) begin
      wmask = CP_WMASK;
    end else if (a == ADDR_I_FINE || a == ADDR_Q_FINE) begin
      wmask = FINE_WMASK;
    end else if (a == ADDR_I_COARSE || a == ADDR_Q_COARSE) begin
      wmask = COARSE_WMASK;
    end else if (a == ADDR_I_OFS_HI || a == ADDR_Q_OFS_HI) begin
      wmask = OFS_HI_WMASK;
    end else if (a == ADDR_I_OFS_LO || a == ADDR_Q_OFS_LO) begin
      wmask = OFS_LO_WMASK;
    end else begin
      wmask = 8'h00;
    end
  endfunction : wmask

  logic lsb_first;
  logic bidir;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] rx_byte;
  logic byte_done;
  logic wr_fire;
  logic soft_rst;
  logic drive;

  assign lsb_first = st.regs[ADDR_CFG][CFG_LSB_BIT];
  assign bidir = st.regs[ADDR_CFG][CFG_BIDIR_BIT];
  // (RULE19) edges counted once second and third stage agree
  assign sclk_rise = (st.sclk_sync[1] == st.sclk_sync[2]) && st.sclk_sync[2] && !st.sclk_st;
  assign sclk_fall = (st.sclk_sync[1] == st.sclk_sync[2]) && !st.sclk_sync[2] && st.sclk_st;
  // data stage has the same depth as clock stage, so they stay aligned
  assign rx_byte = shift_in(st.shreg, st.sdi_sync[2], lsb_first);
  assign byte_done = !st.cs_st && sclk_rise && (st.bitcnt == LAST_BIT);
  assign wr_fire = byte_done && (st.phase == PH_DATA) && !st.rw;
  assign soft_rst = wr_fire && (st.addr == ADDR_CFG) && rx_byte[CFG_SWRST_BIT];

  always_comb begin
    next_st = st;
    next_st.cs_sync = {st.cs_sync[1:0], chip_select_low};
    next_st.sclk_sync = {st.sclk_sync[1:0], sclk};
    next_st.sdi_sync = {st.sdi_sync[1:0], sdio_in};
    if (st.cs_sync[1] == st.cs_sync[2]) begin
      next_st.cs_st = st.cs_sync[2];
    end
    if (st.sclk_sync[1] == st.sclk_sync[2]) begin
      next_st.sclk_st = st.sclk_sync[2];
    end
    if (st.cs_st) begin
      // (RULE10) deselect returns sequencing to instruction start
      next_st.phase = PH_INSTR;
      // (RULE11) partial byte dropped on abort
      next_st.bitcnt = 3'h0;
      next_st.shreg = 8'h00;
    end else if (sclk_rise) begin
      // (RULE19) sample on rising edge
      next_st.shreg = rx_byte;
      next_st.bitcnt = st.bitcnt + 3'h1;
      if (st.bitcnt == LAST_BIT) begin
        case (st.phase)
          PH_INSTR: begin
            // (RULE9) eighth rising edge completes instruction
            // (RULE13) direction bit
            next_st.rw = rx_byte[INSTR_RW_BIT];
            // (RULE14) byte count field
            next_st.nleft = rx_byte[6:5];
            // (RULE15) start address field
            next_st.addr = rx_byte[4:0];
            next_st.phase = PH_DATA;
            // (RULE23) first read byte ready for falling edge
            next_st.txreg = read_reg(st.regs, rx_byte[4:0]);
          end
          PH_DATA: begin
            if (!st.rw && held_addr(st.addr)) begin
              // (RULE12) commit at last bit of each byte
              next_st.regs[st.addr[3:0]] = rx_byte & wmask(st.addr);
            end
            if (soft_rst) begin
              // soft reset clears everything except the port config
              for (int k = 1; k < REG_SLOTS; k++) begin
                next_st.regs[k] = REG_RESET;
              end
            end
            if (st.nleft == 2'h0) begin
              next_st.phase = PH_DONE;
            end else begin
              next_st.nleft = st.nleft - 2'h1;
              // (RULE16) internal address generation
              // (RULE21) direction follows bit order in force now
              next_st.addr = step_addr(st.addr, lsb_first);
              // (RULE23) next byte loaded for reading
              next_st.txreg = read_reg(next_st.regs, step_addr(st.addr, lsb_first));
            end
          end
          default: begin
            next_st.phase = PH_DONE;
          end
        endcase
      end
    end else if (sclk_fall && st.phase == PH_DATA && st.rw) begin
      // (RULE19) drive on falling edge
      next_st.tx_bit = lsb_first ? st.txreg[0] : st.txreg[7];
      next_st.txreg = lsb_first ? {1'b0, st.txreg[7:1]} : {st.txreg[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.cs_sync <= SYNC_IDLE_HIGH;
      st.cs_st <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // pin direction; release lags chip select by the synchroniser depth
  // (RULE20) released while deselected
  assign drive = !st.cs_st && (st.phase == PH_DATA) && st.rw;
  // (RULE17) wiring mode picks the output pin
  // (RULE22) bidirectional pin drives only when configured
  assign sdio_oe_n = !(drive && bidir);
  assign serial_data_output_oe_n = !(drive && !bidir);
  assign sdio_out = st.tx_bit;
  assign serial_data_output = st.tx_bit;

  // (RULE18) only this flag leaves the port; the port itself never gates on it
  assign power_down = st.regs[ADDR_CFG][CFG_PD_BIT];
  // (RULE2) pll enable
  assign pll_enable = st.regs[ADDR_CP][CP_PLL_EN_BIT];
  // (RULE1) divide ratio decode
  assign clk_div_code = st.regs[ADDR_DIV][1:0];
  assign clk_div_ratio = 4'h1 << clk_div_code;
  // (RULE3) charge pump mode
  assign cp_manual = st.regs[ADDR_CP][CP_MANUAL_BIT];
  // (RULE4) bias code ignored in automatic mode
  assign cp_bias_code = cp_manual ? st.regs[ADDR_CP][2:0] : 3'h0;
  // (RULE5) fine gain
  assign chan_i.fine = st.regs[ADDR_I_FINE];
  assign chan_q.fine = st.regs[ADDR_Q_FINE];
  // (RULE6) coarse gain
  assign chan_i.coarse = st.regs[ADDR_I_COARSE][3:0];
  assign chan_q.coarse = st.regs[ADDR_Q_COARSE][3:0];
  // (RULE7) ten-bit offset magnitude
  assign chan_i.offset = {st.regs[ADDR_I_OFS_HI], st.regs[ADDR_I_OFS_LO][1:0]};
  assign chan_q.offset = {st.regs[ADDR_Q_OFS_HI], st.regs[ADDR_Q_OFS_LO][1:0]};
  // (RULE8) offset direction
  assign chan_i.offset_to_b = st.regs[ADDR_I_OFS_LO][OFS_DIR_BIT];
  assign chan_q.offset_to_b = st.regs[ADDR_Q_OFS_LO][OFS_DIR_BIT];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_deselect_restart: assert property ( // RULE10
    st.cs_st |=> (st.phase == PH_INSTR) && (st.bitcnt == 3'h0))
    else $error("deselect did not restart instruction phase");

  a_no_partial_write: assert property ( // RULE11
    !wr_fire |=> $stable(st.regs))
    else $error("register changed without a completed byte");

  a_instr_decode: assert property ( // RULE13
    (byte_done && st.phase == PH_INSTR) |=> (st.phase == PH_DATA)
      && (st.rw == $past(rx_byte[7])) && (st.nleft == $past(rx_byte[6:5]))
      && (st.addr == $past(rx_byte[4:0])))
    else $error("instruction byte decoded wrongly");

  a_write_commit: assert property ( // RULE12
    (wr_fire && st.addr == ADDR_I_FINE) |=> (chan_i.fine == $past(rx_byte)))
    else $error("fine gain not updated at last bit");

  a_addr_step: assert property ( // RULE21
    (byte_done && st.phase == PH_DATA && st.nleft != 2'h0 && !soft_rst
      && st.addr != ADDR_CFG)
      |=> st.addr == (lsb_first ? $past(st.addr) + 5'h01 : $past(st.addr) - 5'h01))
    else $error("byte address stepped the wrong way");

  a_last_byte_done: assert property ( // RULE14
    (byte_done && st.phase == PH_DATA && st.nleft == 2'h0) |=> st.phase == PH_DONE)
    else $error("data phase ran past its byte count");

  a_idle_release: assert property ( // RULE20
    st.cs_st |-> sdio_oe_n && serial_data_output_oe_n)
    else $error("data pin driven while deselected");

  a_sdio_input_only: assert property ( // RULE22
    !bidir |-> sdio_oe_n)
    else $error("bidirectional pin driven in input-only mode");

  a_read_drives: assert property ( // RULE23
    (byte_done && st.phase == PH_INSTR && rx_byte[7] && !bidir)
      |=> !serial_data_output_oe_n [*2])
    else $error("read data not driven after instruction");

  a_cp_auto_ignore: assert property ( // RULE4
    !cp_manual |-> cp_bias_code == 3'h0)
    else $error("bias code passed in automatic mode");

  a_pll_enable_src: assert property ( // RULE2
    $changed(pll_enable) |-> $past(wr_fire && (st.addr == ADDR_CP || soft_rst)))
    else $error("pll enable changed without a write");

  a_pd_port_alive: assert property ( // RULE18
    (power_down && byte_done && st.phase == PH_INSTR) |=> st.phase == PH_DATA)
    else $error("port stalled in power-down");

  // soft reset, divider, pin timing, commit and write-gating guards
  a_soft_clear: assert property ( // RULE2
    soft_rst |=> (st.regs[ADDR_CP] == 8'h00) && (chan_i == '0) && (chan_q == '0))
    else $error("soft reset left a register set");

  a_cfg_survives: assert property ( // RULE12
    soft_rst |=> st.regs[ADDR_CFG] == ($past(rx_byte) & CFG_WMASK))
    else $error("soft reset disturbed the port config");

  a_div_ratio_top: assert property ( // RULE1
    (clk_div_code == 2'h3) |-> (clk_div_ratio == 4'h8))
    else $error("divider code three is not divide by eight");

  a_tx_bit_order: assert property ( // RULE19
    (sclk_fall && !st.cs_st && st.phase == PH_DATA && st.rw)
      |=> st.tx_bit == $past(lsb_first ? st.txreg[0] : st.txreg[7]))
    else $error("read bit shifted out in the wrong order");

  a_read_release: assert property ( // RULE23
    (byte_done && st.phase == PH_DATA && st.rw && st.nleft == 2'h0)
      |=> sdio_oe_n && serial_data_output_oe_n)
    else $error("data pin still driven after the last read byte");

  a_cs_filtered: assert property ( // RULE10
    $changed(st.cs_st) |-> $past(st.cs_sync[1] == st.cs_sync[2]))
    else $error("chip select accepted before its stages agreed");

  a_read_no_write: assert property ( // RULE13
    (byte_done && st.phase == PH_DATA && st.rw) |=> $stable(st.regs))
    else $error("read cycle changed a register");

  a_unheld_ignored: assert property ( // RULE15
    (wr_fire && !held_addr(st.addr)) |=> $stable(st.regs))
    else $error("write to an unheld address changed a register");

  a_drive_on_fall: assert property ( // RULE19
    $changed(st.tx_bit) |-> $past(sclk_fall))
    else $error("read bit changed away from a falling edge");

  a_sample_on_rise: assert property ( // RULE9
    ($changed(st.shreg) && !$past(st.cs_st)) |-> $past(sclk_rise))
    else $error("input shifted away from a rising edge");

  a_q_fine_commit: assert property ( // RULE5
    (wr_fire && st.addr == ADDR_Q_FINE) |=> (chan_q.fine == $past(rx_byte)))
    else $error("q fine gain not updated at last bit");

  a_ofs_dir_commit: assert property ( // RULE8
    (wr_fire && st.addr == ADDR_I_OFS_LO) |=> chan_i.offset_to_b == $past(rx_byte[OFS_DIR_BIT]))
    else $error("offset direction not taken from bit 7");

  a_instr_no_write: assert property ( // RULE9
    (byte_done && st.phase == PH_INSTR) |=> $stable(st.regs))
    else $error("instruction byte changed a register");

  c_write_done: cover property (wr_fire ##1 st.phase == PH_DONE);
  c_read_byte: cover property (drive && sclk_fall);
  c_abort_mid: cover property (st.phase == PH_DATA && st.bitcnt == 3'h4 ##1 st.cs_st);
  c_soft_reset: cover property (soft_rst);
  c_lsb_read: cover property (lsb_first && drive && sclk_fall);

endmodule : dscp_serial_port

// >>> verification/dscp_host_model.sv
`timescale 1ns/1ps

module dscp_host_model (
  input wire logic clk,
  output logic sclk,
  output logic chip_select_low,
  output logic host_d,
  output logic host_oe_n,
  input wire logic sdio_line,
  input wire logic out_line
);
  initial begin
    sclk = 1'b0;
    chip_select_low = 1'b1;
    host_d = 1'b0;
    host_oe_n = 1'b0;
  end

  task automatic wait_clks(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clks

  // nbits short of a whole frame aborts it mid-byte
  task automatic cycle(input logic [7:0] instr, input logic [31:0] wdata, input logic lsb,
                       input logic bidir, input int nbits, output logic [31:0] rdata);
    logic tx;
    int k;
    int j;
    rdata = 32'h0;
    @(posedge clk);
    chip_select_low <= 1'b0;
    wait_clks(6);
    for (int i = 0; i < nbits; i++) begin
      k = i / 8;
      j = lsb ? i % 8 : 7 - i % 8;
      // instruction on first eight rising edges
      tx = (k == 0) ? instr[j] : wdata[8*(k-1)+j];
      // change on falling, sample before rising
      sclk <= 1'b0;
      host_d <= tx;
      host_oe_n <= instr[7] && bidir && (k > 0);
      wait_clks(5);
      #1;
      if (k > 0) rdata[8*(k-1)+j] = bidir ? sdio_line : out_line;
      @(posedge clk);
      sclk <= 1'b1;
      // let go of the shared pin before the device starts driving it
      if (i == 7) host_oe_n <= instr[7] && bidir;
      wait_clks(6);
    end
    // clock stands low between frames
    chip_select_low <= 1'b1;
    sclk <= 1'b0;
    host_oe_n <= 1'b0;
    wait_clks(6);
  endtask : cycle
endmodule : dscp_host_model

// >>> verification/tb_top.sv
`timescale 1ns/1ps

module tb_top import dscp_pkg::*;;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wval;
    logic [7:0] rexp;
  } dscp_row_s;

  localparam dscp_row_s ROWS [11] = '{'{ADDR_DIV, 8'hFF, 8'h03}, '{ADDR_CP, 8'hFF, 8'hC7},
    '{ADDR_I_FINE, 8'hA5, 8'hA5}, '{ADDR_I_COARSE, 8'hFF, 8'h0F}, '{ADDR_I_OFS_HI, 8'h3C, 8'h3C},
    '{ADDR_I_OFS_LO, 8'hFF, 8'h83}, '{ADDR_Q_FINE, 8'h5A, 8'h5A}, '{ADDR_Q_COARSE, 8'hF7, 8'h07},
    '{ADDR_Q_OFS_HI, 8'hC3, 8'hC3}, '{ADDR_Q_OFS_LO, 8'h81, 8'h81}, '{5'h01, 8'hFF, 8'h00}};

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sclk, cs_n, host_d, host_oe_n, sdio_line, out_line, lsb_mode, bidir_mode;
  logic sdio_out, sdio_oe_n, data_out, data_oe_n, power_down, pll_enable, cp_manual;
  logic [1:0] clk_div_code;
  logic [3:0] clk_div_ratio;
  logic [2:0] cp_bias_code;
  logic [31:0] rd;
  dscp_chan_s chan_i, chan_q, ei;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // undriven lines show the inverse so a stale bit cannot pass
  assign sdio_line = !host_oe_n ? host_d : (!sdio_oe_n ? sdio_out : ~sdio_out);
  assign out_line = !data_oe_n ? data_out : ~data_out;

  dscp_serial_port u_dut (.clk(clk), .resetn(resetn), .sclk(sclk), .chip_select_low(cs_n),
    .sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .serial_data_output(data_out), .serial_data_output_oe_n(data_oe_n),
    .power_down(power_down), .pll_enable(pll_enable), .clk_div_code(clk_div_code),
    .clk_div_ratio(clk_div_ratio), .cp_manual(cp_manual), .cp_bias_code(cp_bias_code),
    .chan_i(chan_i), .chan_q(chan_q));

  dscp_host_model u_host (.clk(clk), .sclk(sclk), .chip_select_low(cs_n), .host_d(host_d),
    .host_oe_n(host_oe_n), .sdio_line(sdio_line), .out_line(out_line));

  always #10 clk = ~clk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic xfer(input logic [7:0] instr, input logic [31:0] wd, input int nbits);
    u_host.cycle(instr, wd, lsb_mode, bidir_mode, nbits, rd);
    #1;
  endtask : xfer

  initial begin
    lsb_mode = 1'b0;
    bidir_mode = 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    cmp("pll_enable", 32'h0, 32'(pll_enable));
    cmp("cp_manual", 32'h0, 32'(cp_manual));
    cmp("ratio", 32'h1, 32'(clk_div_ratio));
    cmp("oe pair", 32'h3, 32'({sdio_oe_n, data_oe_n}));
    foreach (ROWS[n]) begin
      xfer({3'b000, ROWS[n].addr}, 32'(ROWS[n].wval), 16);
      xfer({3'b100, ROWS[n].addr}, 32'h0, 16);
      cmp("readback", 32'(ROWS[n].rexp), rd);
    end
    cmp("pll_enable", 32'h1, 32'(pll_enable));
    cmp("cp bias", 32'hF, 32'({cp_manual, cp_bias_code}));
    cmp("chan_i", 32'({8'hA5, 4'hF, 10'h0F3, 1'b1}), 32'(chan_i));
    cmp("chan_q", 32'({8'h5A, 4'h7, 10'h30D, 1'b1}), 32'(chan_q));
    for (int c = 0; c < 4; c++) begin
      xfer({3'b000, ADDR_DIV}, 32'(c), 16);
      cmp("ratio", 32'(4'h1 << c), 32'(clk_div_ratio));
      cmp("div code", 32'(c), 32'(clk_div_code));
    end
    xfer({3'b000, ADDR_CP}, 32'h85, 16);
    cmp("cp auto", 32'h0, 32'({cp_manual, cp_bias_code}));
    // three bytes from 07h walk down to 05h
    xfer(8'h47, 32'h00330211, 32);
    ei = {8'h33, 4'h2, 10'h047, 1'b1};
    cmp("chan_i", 32'(ei), 32'(chan_i));
    // second byte cut after four bits
    xfer(8'h29, 32'h00000077, 20);
    cmp("q fine", 32'h77, 32'(chan_q.fine));
    cmp("chan_i", 32'(ei), 32'(chan_i));
    xfer(8'hFF, 32'h0, 4);
    xfer({3'b000, ADDR_I_FINE}, 32'h9C, 16);
    cmp("i fine", 32'h9C, 32'(chan_i.fine));
    xfer(8'hA6, 32'h0, 24);
    cmp("two byte read", 32'h9C02, rd);
    xfer({3'b000, ADDR_CFG}, 32'h80, 16);
    bidir_mode = 1'b1;
    xfer({3'b100, ADDR_I_FINE}, 32'h0, 16);
    cmp("bidir read", 32'h9C, rd);
    xfer({3'b000, ADDR_CFG}, 32'h88, 16);
    cmp("power_down", 32'h1, 32'(power_down));
    xfer({3'b000, ADDR_Q_FINE}, 32'h3E, 16);
    xfer({3'b100, ADDR_Q_FINE}, 32'h0, 16);
    cmp("read in power-down", 32'h3E, rd);
    xfer({3'b000, ADDR_CFG}, 32'h40, 16);
    bidir_mode = 1'b0;
    lsb_mode = 1'b1;
    // lsb first: 0Bh then 0Ch
    xfer(8'h2B, 32'h00008012, 24);
    cmp("chan_q", 32'({8'h3E, 4'h7, 10'h048, 1'b1}), 32'(chan_q));
    // soft reset clears all but the port config, lsb order stays in force
    xfer({3'b000, ADDR_CFG}, 32'h60, 16);
    cmp("pll after soft reset", 32'h0, 32'(pll_enable));
    cmp("chan_q after soft reset", 32'h0, 32'(chan_q));
    xfer({3'b100, ADDR_CFG}, 32'h0, 16);
    cmp("cfg lsb readback", 32'h40, rd);
    final_report();
  end
endmodule : tb_top
